//--- verilog/sbwog_map.svh
`ifndef SBWOG_MAP_SVH
`define SBWOG_MAP_SVH

// ****************************************
// clock and timing
// ****************************************
`define SBWOG_CLK_MHZ 20
`define SBWOG_T_DRVPD_US 300
`define SBWOG_T_STAB_US 1000
`define SBWOG_F_SMB_KHZ 400
`define SBWOG_QTR_CYC ((`SBWOG_CLK_MHZ * 1000 + 4 * `SBWOG_F_SMB_KHZ - 1) / (4 * `SBWOG_F_SMB_KHZ))
`define SBWOG_REF_TIMEOUT 64

// ****************************************
// target addresses by strap level
// ****************************************
`define SBWOG_STRAP_LOW 2'h0
`define SBWOG_STRAP_MID 2'h1
`define SBWOG_STRAP_HIGH 2'h2
`define SBWOG_ADDR_LOW 7'h6b
`define SBWOG_ADDR_MID 7'h6c
`define SBWOG_ADDR_HIGH 7'h6d

// ****************************************
// configuration bytes
// ****************************************
`define SBWOG_NREG 8
`define SBWOG_REG_RESET 8'hff
`define SBWOG_OE_LO_BYTE 0
`define SBWOG_OE_HI_BYTE 1

`endif

//--- verilog/sbwog_pkg.sv
package sbwog_pkg;

  typedef enum logic [3:0] {
    SBWOG_RX_IDLE = 4'h0,
    SBWOG_RX_ADDR = 4'h1,
    SBWOG_RX_ADDR_ACK = 4'h3,
    SBWOG_RX_INDEX = 4'h2,
    SBWOG_RX_INDEX_ACK = 4'h6,
    SBWOG_RX_COUNT = 4'h7,
    SBWOG_RX_COUNT_ACK = 4'h5,
    SBWOG_RX_DATA = 4'h4,
    SBWOG_RX_DATA_ACK = 4'hc,
    SBWOG_RX_IGNORE = 4'h8
  } sbwog_rx_t;

  typedef enum logic [2:0] {
    SBWOG_H_IDLE = 3'h0,
    SBWOG_H_START = 3'h1,
    SBWOG_H_BYTE = 3'h3,
    SBWOG_H_WAIT = 3'h2,
    SBWOG_H_STOP = 3'h6
  } sbwog_host_st_t;

  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } sbwog_wr_t;

endpackage

//--- verilog/sbwog_if.sv
`timescale 1ns/1ns
interface sbwog_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // open-drain wire with pull-up: any enabled low driver wins
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface

//--- verilog/sbwog_device.sv
// Function
// - start then address with write bit acknowledged
// - index byte acknowledged, sets first location
// - byte count acknowledged after index
// - count data bytes, each acknowledged, consecutive; a full two-entry buffer refuses the byte
// - host ends write with stop
// - serial clock at most 400 kHz
// - serial port live only while reference toggles
// - enable pin acts within 1 to 3 cycles
// - outputs driven within 300 us after wake
// - first clock within 1 ms of start
// - power good latches straps, low powers down
// - enable pins active low per pair
// - three-level strap selects target address
`timescale 1ns/1ns
`include "sbwog_map.svh"
module sbwog_device #(
  parameter int NOUT = 9,
  parameter int NREG = `SBWOG_NREG,
  parameter int WAKE_CYC = `SBWOG_T_DRVPD_US * `SBWOG_CLK_MHZ,
  parameter int STAB_CYC = `SBWOG_T_STAB_US * `SBWOG_CLK_MHZ,
  parameter int REF_TIMEOUT = `SBWOG_REF_TIMEOUT
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  sbwog_if.dev bus,
  input wire logic reference_clock_in,
  input wire logic power_good_pin,
  input wire logic [1:0] addr_strap_pin,
  input wire logic [NOUT-1:0] oe_n_pin,
  input wire logic cfg_hold,
  output logic [NOUT-1:0] buffered_clock_pair_p,
  output logic [NOUT-1:0] buffered_clock_pair_n,
  output logic [NREG*8-1:0] cfg_image,
  output logic smb_active,
  output logic powered_down
);
  localparam int WDW = $clog2(REF_TIMEOUT + 1);
  localparam int WKW = $clog2(WAKE_CYC + 1);
  localparam int IW = (NREG > 1) ? $clog2(NREG) : 1;

  if (NOUT < 1 || NOUT > 16 || NREG < 2 || NREG > 256 || WAKE_CYC < 1
      || WAKE_CYC > STAB_CYC || REF_TIMEOUT < 2) begin
    $error("sbwog_device: unsupported parameter values");
  end

  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_p;
    logic sda_p;
    logic [1:0] ref_s;
    logic ref_p;
    logic [1:0] pg_s;
    logic pg_p;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [WDW-1:0] refwd;
    logic ref_run;
    logic started;
    logic pd;
    logic [6:0] addr;
    logic [WKW-1:0] wake;
    logic awake;
    logic [NOUT-1:0] oe_s1;
    logic [NOUT-1:0] oe_s2;
    logic [NOUT-1:0] en1;
    logic [NOUT-1:0] en2;
    logic [NOUT-1:0] out_p;
    logic [NOUT-1:0] out_n;
    sbwog_pkg::sbwog_rx_t rx;
    logic [7:0] shreg;
    logic [3:0] bcnt;
    logic ack_oe;
    logic [7:0] idx;
    logic [7:0] left;
    sbwog_pkg::sbwog_wr_t [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] fcnt;
    logic [NREG-1:0][7:0] regs;
  } sbwog_dev_state_t;

  sbwog_dev_state_t q;
  sbwog_dev_state_t n;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  logic ref_lvl;
  logic ref_edge;
  logic pg_lvl;
  logic pg_rise;
  logic active;
  logic push;
  logic pop;
  logic [15:0] oe_cfg;
  logic [6:0] strap_addr;
  sbwog_pkg::sbwog_wr_t head;

  always_comb begin
    n = q;
    // ****************************************
    // pin synchronisers and edge finders
    // ****************************************
    n.scl_s = {q.scl_s[0], bus.scl};
    n.sda_s = {q.sda_s[0], bus.sda};
    n.ref_s = {q.ref_s[0], reference_clock_in};
    n.pg_s = {q.pg_s[0], power_good_pin};
    n.strap_s1 = addr_strap_pin;
    n.strap_s2 = q.strap_s1;
    n.oe_s1 = oe_n_pin;
    n.oe_s2 = q.oe_s1;
    scl = q.scl_s[1];
    sda = q.sda_s[1];
    ref_lvl = q.ref_s[1];
    pg_lvl = q.pg_s[1];
    n.scl_p = scl;
    n.sda_p = sda;
    n.ref_p = ref_lvl;
    n.pg_p = pg_lvl;
    scl_rise = scl & ~q.scl_p;
    scl_fall = ~scl & q.scl_p;
    bus_start = scl & q.scl_p & q.sda_p & ~sda;
    bus_stop = scl & q.scl_p & ~q.sda_p & sda;
    ref_edge = ref_lvl & ~q.ref_p;
    pg_rise = pg_lvl & ~q.pg_p;

    // ****************************************
    // reference activity watchdog
    // ****************************************
    // a stopped reference is seen only after the timeout; keep it above one ref period
    if (ref_edge) begin
      n.refwd = '0;
      n.ref_run = 1'b1;
    end else if (q.refwd == WDW'(REF_TIMEOUT - 1)) begin
      n.ref_run = 1'b0;
    end else begin
      n.refwd = q.refwd + 1'b1;
    end

    // ****************************************
    // power good, straps and wake timer
    // ****************************************
    case (q.strap_s2)
      `SBWOG_STRAP_MID: strap_addr = `SBWOG_ADDR_MID;
      `SBWOG_STRAP_HIGH: strap_addr = `SBWOG_ADDR_HIGH;
      default: strap_addr = `SBWOG_ADDR_LOW;
    endcase
    if (pg_rise) begin
      if (!q.started) begin
        n.started = 1'b1;
        n.addr = strap_addr;
      end
      n.pd = 1'b0;
      n.wake = '0;
      n.awake = 1'b0;
    end else if (!pg_lvl) begin
      n.pd = 1'b1;
      n.awake = 1'b0;
    end else if (q.started && !q.awake) begin
      // one timer serves both bounds since the drive bound is the shorter
      if (q.wake == WKW'(WAKE_CYC - 1)) begin
        n.awake = 1'b1;
      end else begin
        n.wake = q.wake + 1'b1;
      end
    end

    // ****************************************
    // output gating
    // ****************************************
    oe_cfg = {q.regs[`SBWOG_OE_HI_BYTE], q.regs[`SBWOG_OE_LO_BYTE]};
    if (q.pd || !q.awake) begin
      n.en1 = '0;
      n.en2 = '0;
    end else if (ref_edge) begin
      // two reference edges from pin change to gated output
      n.en1 = ~q.oe_s2 & oe_cfg[NOUT-1:0];
      n.en2 = q.en1;
    end
    n.out_p = q.en2 & {NOUT{ref_lvl}};
    n.out_n = q.en2 & {NOUT{~ref_lvl}};

    // ****************************************
    // serial receiver
    // ****************************************
    active = q.ref_run & q.started & ~q.pd;
    push = 1'b0;
    if (!active || bus_stop) begin
      n.rx = sbwog_pkg::SBWOG_RX_IDLE;
      n.ack_oe = 1'b0;
    end else if (bus_start) begin
      n.rx = sbwog_pkg::SBWOG_RX_ADDR;
      n.bcnt = '0;
      n.ack_oe = 1'b0;
    end else begin
      case (q.rx)
        sbwog_pkg::SBWOG_RX_ADDR, sbwog_pkg::SBWOG_RX_INDEX,
        sbwog_pkg::SBWOG_RX_COUNT, sbwog_pkg::SBWOG_RX_DATA: begin
          if (scl_rise) begin
            n.shreg = {q.shreg[6:0], sda};
            n.bcnt = q.bcnt + 1'b1;
          end else if (scl_fall && q.bcnt == 4'h8) begin
            n.bcnt = '0;
            n.rx = sbwog_pkg::SBWOG_RX_IGNORE;
            case (q.rx)
              sbwog_pkg::SBWOG_RX_ADDR: begin
                // read direction is not served and is left unacknowledged
                if (q.shreg[7:1] == q.addr && !q.shreg[0]) begin
                  n.ack_oe = 1'b1;
                  n.rx = sbwog_pkg::SBWOG_RX_ADDR_ACK;
                end
              end
              sbwog_pkg::SBWOG_RX_INDEX: begin
                n.idx = q.shreg;
                n.ack_oe = 1'b1;
                n.rx = sbwog_pkg::SBWOG_RX_INDEX_ACK;
              end
              sbwog_pkg::SBWOG_RX_COUNT: begin
                n.left = q.shreg;
                n.ack_oe = 1'b1;
                n.rx = sbwog_pkg::SBWOG_RX_COUNT_ACK;
              end
              default: begin
                // a full buffer refuses the byte, so the host sees the stall
                if (q.left != 8'h00 && q.fcnt != 2'h2) begin
                  push = 1'b1;
                  n.idx = q.idx + 8'h01;
                  n.left = q.left - 8'h01;
                  n.ack_oe = 1'b1;
                  n.rx = sbwog_pkg::SBWOG_RX_DATA_ACK;
                end
              end
            endcase
          end
        end
        sbwog_pkg::SBWOG_RX_ADDR_ACK, sbwog_pkg::SBWOG_RX_INDEX_ACK,
        sbwog_pkg::SBWOG_RX_COUNT_ACK, sbwog_pkg::SBWOG_RX_DATA_ACK: begin
          if (scl_fall) begin
            n.ack_oe = 1'b0;
            case (q.rx)
              sbwog_pkg::SBWOG_RX_ADDR_ACK: n.rx = sbwog_pkg::SBWOG_RX_INDEX;
              sbwog_pkg::SBWOG_RX_INDEX_ACK: n.rx = sbwog_pkg::SBWOG_RX_COUNT;
              default: n.rx = sbwog_pkg::SBWOG_RX_DATA;
            endcase
          end
        end
        default: begin
          n.ack_oe = 1'b0;
        end
      endcase
    end

    // ****************************************
    // two-entry write buffer and byte store
    // ****************************************
    head = q.fifo[q.rp];
    pop = (q.fcnt != 2'h0) & q.ref_run & ~cfg_hold;
    if (push) begin
      n.fifo[q.wp] = '{idx: q.idx, data: q.shreg};
      n.wp = ~q.wp;
    end
    if (pop) begin
      n.rp = ~q.rp;
      // bytes beyond the implemented range are acknowledged and dropped
      if ({1'b0, head.idx} < 9'(NREG)) begin
        n.regs[head.idx[IW-1:0]] = head.data;
      end
    end
    n.fcnt = q.fcnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.pd <= 1'b1;
      q.addr <= `SBWOG_ADDR_LOW;
      q.rx <= sbwog_pkg::SBWOG_RX_IDLE;
      q.regs <= {NREG{`SBWOG_REG_RESET}};
    end else begin
      q <= n;
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = q.ack_oe;
  assign buffered_clock_pair_p = q.out_p;
  assign buffered_clock_pair_n = q.out_n;
  assign cfg_image = q.regs;
  assign smb_active = q.ref_run & q.started & ~q.pd;
  assign powered_down = q.pd;
endmodule

//--- verilog/sbwog_host.sv
`timescale 1ns/1ns
`include "sbwog_map.svh"
module sbwog_host #(
  parameter int QTR_CYC = `SBWOG_QTR_CYC
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  sbwog_if.host bus,
  input wire logic xfer_valid,
  output logic xfer_ready,
  input wire logic [6:0] xfer_addr,
  input wire logic [7:0] xfer_index,
  input wire logic [7:0] xfer_count,
  input wire logic data_valid,
  output logic data_ready,
  input wire logic [7:0] data_byte,
  output logic busy,
  output logic done,
  output logic nacked
);
  localparam int QW = $clog2(QTR_CYC + 1);

  // a shorter quarter would clock the bus above 400 kHz
  if (QTR_CYC < `SBWOG_QTR_CYC) begin
    $error("sbwog_host: quarter period too short");
  end

  typedef struct packed {
    sbwog_pkg::sbwog_host_st_t st;
    logic [QW-1:0] qc;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [1:0] stage;
    logic [7:0] idx;
    logic [7:0] left;
    logic [1:0] sda_s;
    logic scl;
    logic oe;
    logic nack;
    logic done;
  } sbwog_host_state_t;

  sbwog_host_state_t q;
  sbwog_host_state_t n;
  logic tick;

  always_comb begin
    n = q;
    n.done = 1'b0;
    n.sda_s = {q.sda_s[0], bus.sda};
    tick = (q.qc == QW'(QTR_CYC - 1));
    n.qc = tick ? '0 : q.qc + 1'b1;
    case (q.st)
      sbwog_pkg::SBWOG_H_IDLE: begin
        n.qc = '0;
        n.scl = 1'b1;
        n.oe = 1'b0;
        if (xfer_valid) begin
          n.st = sbwog_pkg::SBWOG_H_START;
          n.ph = 2'h0;
          n.idx = xfer_index;
          n.left = xfer_count;
          n.sh = {xfer_addr, 1'b0};
          n.nack = 1'b0;
          n.oe = 1'b1;
        end
      end
      sbwog_pkg::SBWOG_H_START: begin
        if (tick) begin
          n.scl = 1'b0;
          n.oe = ~q.sh[7];
          n.st = sbwog_pkg::SBWOG_H_BYTE;
          n.bitn = 4'h0;
          n.ph = 2'h0;
          n.stage = 2'h0;
        end
      end
      sbwog_pkg::SBWOG_H_BYTE: begin
        if (tick) begin
          n.ph = q.ph + 2'h1;
          case (q.ph)
            2'h0: n.scl = 1'b1;
            2'h1: begin
              if (q.bitn == 4'h8) begin
                n.nack = q.sda_s[1];
              end
            end
            2'h2: begin
              n.scl = 1'b0;
              // let go of data with the eighth fall so the target's acknowledge never overlaps us
              if (q.bitn == 4'h7) begin
                n.oe = 1'b0;
              end
            end
            default: begin
              if (q.bitn != 4'h8) begin
                n.bitn = q.bitn + 4'h1;
                n.sh = {q.sh[6:0], 1'b0};
                n.oe = (q.bitn == 4'h7) ? 1'b0 : ~q.sh[6];
              end else begin
                n.bitn = 4'h0;
                n.stage = (q.stage == 2'h3) ? 2'h3 : q.stage + 2'h1;
                if (q.nack) begin
                  n.oe = 1'b1;
                  n.st = sbwog_pkg::SBWOG_H_STOP;
                end else if (q.stage == 2'h0) begin
                  n.sh = q.idx;
                  n.oe = ~q.idx[7];
                end else if (q.stage == 2'h1) begin
                  n.sh = q.left;
                  n.oe = ~q.left[7];
                end else if (q.left == 8'h00) begin
                  n.oe = 1'b1;
                  n.st = sbwog_pkg::SBWOG_H_STOP;
                end else begin
                  n.oe = 1'b0;
                  n.st = sbwog_pkg::SBWOG_H_WAIT;
                end
              end
            end
          endcase
        end
      end
      sbwog_pkg::SBWOG_H_WAIT: begin
        // scl stays low while the data source stalls
        n.qc = '0;
        if (data_valid) begin
          n.sh = data_byte;
          n.oe = ~data_byte[7];
          n.left = q.left - 8'h01;
          n.ph = 2'h0;
          n.st = sbwog_pkg::SBWOG_H_BYTE;
        end
      end
      sbwog_pkg::SBWOG_H_STOP: begin
        if (tick) begin
          if (!q.scl) begin
            n.scl = 1'b1;
          end else if (q.oe) begin
            n.oe = 1'b0;
          end else begin
            // a quarter of bus free time keeps the next frame's first rise a full period away
            n.done = 1'b1;
            n.st = sbwog_pkg::SBWOG_H_IDLE;
          end
        end
      end
      default: n.st = sbwog_pkg::SBWOG_H_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.st <= sbwog_pkg::SBWOG_H_IDLE;
      q.scl <= 1'b1;
      q.sda_s <= 2'h3;
    end else begin
      q <= n;
    end
  end

  assign bus.scl = q.scl;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = q.oe;
  assign xfer_ready = (q.st == sbwog_pkg::SBWOG_H_IDLE);
  assign data_ready = (q.st == sbwog_pkg::SBWOG_H_WAIT);
  assign busy = (q.st != sbwog_pkg::SBWOG_H_IDLE);
  assign done = q.done;
  assign nacked = q.nack;
endmodule

//--- testbench/sbwog_props.sv
`timescale 1ns/1ns
module sbwog_props #(
  parameter int QTR = 13
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic scl_q;
  logic [7:0] per_q;
  logic [7:0] fall_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  // ****************************************
  // helper counters
  // ****************************************
  // both saturate so a long idle never wraps into a false short period
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      per_q <= 8'hff;
      fall_q <= 8'hff;
    end else begin
      scl_q <= scl;
      per_q <= (scl && !scl_q) ? 8'h01 : ((per_q == 8'hff) ? per_q : per_q + 8'h01);
      fall_q <= (!scl && scl_q) ? 8'h01 : ((fall_q == 8'hff) ? fall_q : fall_q + 8'h01);
    end
  end

  // ****************************************
  // wire rules
  // ****************************************
  scl_period_a: assert property ($rose(scl) |-> per_q >= 8'h32)
    else $error("serial clock period shorter than 50 cycles");
  ack_delay_a: assert property ($rose(dev_sda_oe) |-> !scl && fall_q <= 8'h05)
    else $error("acknowledge not driven shortly after clock fall");
  ack_hold_a: assert property ($rose(dev_sda_oe) |-> dev_sda_oe until_with $fell(scl))
    else $error("acknowledge released before its clock ended");
  ack_len_a: assert property ($rose(dev_sda_oe) |-> ##[40:70] $fell(dev_sda_oe))
    else $error("acknowledge length outside one bit period");
  dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device moved data while clock high");
  no_fight_a: assert property (dev_sda_oe |-> !host_sda_oe)
    else $error("host and device pull data together");
  od_low_a: assert property (!host_sda_o && !dev_sda_o)
    else $error("open drain value not low");
  stop_idle_a: assert property (scl && $rose(sda) |-> scl [*8])
    else $error("clock left high too soon after stop");
  start_hold_a: assert property (scl && $fell(sda) |-> scl [*8])
    else $error("clock fell too soon after start");

  ack_seen_c: cover property ($rose(dev_sda_oe));
  start_seen_c: cover property (scl && $fell(sda));
  stop_seen_c: cover property (scl && $rose(sda));
endmodule

//--- testbench/tb_smbus_block_write_output_gating.sv
`timescale 1ns/1ns
module tb_smbus_block_write_output_gating;
  localparam int WAKE = 20;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic ref_run = 1'b0;
  logic reference_clock_in = 1'b0;
  logic power_good_pin = 1'b0;
  logic [1:0] addr_strap_pin = 2'h0;
  logic [8:0] oe_n_pin = 9'h000;
  logic cfg_hold = 1'b0;
  logic [8:0] clk_p;
  logic [8:0] clk_n;
  logic [63:0] cfg_image;
  logic smb_active;
  logic powered_down;
  logic xfer_valid = 1'b0;
  logic xfer_ready;
  logic [6:0] xfer_addr = 7'h00;
  logic [7:0] xfer_index = 8'h00;
  logic [7:0] xfer_count = 8'h00;
  logic data_valid = 1'b0;
  logic data_ready;
  logic [7:0] data_byte = 8'h00;
  logic busy;
  logic done;
  logic nacked;
  logic done_seen = 1'b0;
  logic [63:0] exp_img;
  logic [7:0] wq[$];
  logic [6:0] addr_tab [4] = '{7'h6b, 7'h6c, 7'h6d, 7'h6b};
  int fails = 0;
  int n_tests = 0;

  sbwog_if bus ();
  sbwog_device #(.WAKE_CYC(WAKE)) u_sbwog_device (.ref_clk(ref_clk), .reset_n(reset_n),
    .bus(bus), .reference_clock_in(reference_clock_in), .power_good_pin(power_good_pin),
    .addr_strap_pin(addr_strap_pin), .oe_n_pin(oe_n_pin), .cfg_hold(cfg_hold),
    .buffered_clock_pair_p(clk_p), .buffered_clock_pair_n(clk_n), .cfg_image(cfg_image),
    .smb_active(smb_active), .powered_down(powered_down));
  sbwog_host u_sbwog_host (.ref_clk(ref_clk), .reset_n(reset_n), .bus(bus),
    .xfer_valid(xfer_valid), .xfer_ready(xfer_ready), .xfer_addr(xfer_addr),
    .xfer_index(xfer_index), .xfer_count(xfer_count), .data_valid(data_valid),
    .data_ready(data_ready), .data_byte(data_byte), .busy(busy), .done(done),
    .nacked(nacked));
  sbwog_props #(.QTR(13)) u_sbwog_props (.ref_clk(ref_clk), .reset_n(reset_n),
    .scl(bus.scl), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
    .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));

  always #25 ref_clk = ~ref_clk;
  // the reference may stop at either level, as a real source would
  always #200 if (ref_run) reference_clock_in = ~reference_clock_in;
  always @(posedge ref_clk) begin
    if (xfer_valid === 1'b1 && xfer_ready === 1'b1) begin
      done_seen <= 1'b0;
    end else if (done === 1'b1) begin
      done_seen <= 1'b1;
    end
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask

  // 0: request taken, 1: byte taken or frame ended, 2: frame ended
  task automatic wait_for(input int w, input int lim);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge ref_clk);
      if (w == 0 && xfer_ready === 1'b1) break;
      if (w == 1 && (data_ready === 1'b1 || done_seen === 1'b1)) break;
      if (w == 2 && done_seen === 1'b1) break;
    end
    #2;
    if (k == lim) begin
      fails++;
      $display("[ERR] %0t handshake timeout", $time);
      final_report();
    end
  endtask

  // n_ok bytes are expected to be taken; any fewer means a refused frame
  task automatic smb_write(input logic [6:0] a, input logic [7:0] idx, input int n_ok);
    xfer_addr = a;
    xfer_index = idx;
    xfer_count = 8'(wq.size());
    xfer_valid = 1'b1;
    wait_for(0, 100);
    xfer_valid = 1'b0;
    foreach (wq[i]) begin
      if (done_seen !== 1'b1) begin
        data_byte = wq[i];
        data_valid = 1'b1;
        wait_for(1, 8000);
      end
    end
    data_valid = 1'b0;
    wait_for(2, 8000);
    check({busy, xfer_ready}, 2'h1);
    for (int k = 0; k < n_ok; k++) if (idx + k < 8) exp_img[8*(idx+k) +: 8] = wq[k];
    check(nacked, (n_ok != wq.size()));
  endtask

  task automatic watch(input logic [8:0] mask);
    logic [17:0] seen;
    logic [8:0] held;
    seen = 18'h00000;
    repeat (40) begin
      @(posedge ref_clk);
      seen = seen | {clk_p, clk_n};
    end
    #2;
    if (ref_run) begin
      check(seen, {mask, mask});
    end else begin
      // a stopped reference freezes each enabled pair at its last phase
      held = reference_clock_in ? mask : 9'h000;
      check(seen, {held, mask & ~held});
    end
  endtask

  task automatic boot(input logic [1:0] strap);
    reset_n = 1'b0;
    ref_run = 1'b1;
    power_good_pin = 1'b0;
    addr_strap_pin = strap;
    tick(5);
    reset_n = 1'b1;
    exp_img = {8{8'hff}};
    tick(2);
    check({powered_down, smb_active, clk_p}, {2'h2, 9'h000});
    check(cfg_image, exp_img);
    power_good_pin = 1'b1;
    tick(WAKE + 40);
    check({powered_down, smb_active}, 2'h1);
    watch(9'h1ff);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    for (int s = 0; s < 4; s++) begin
      boot(2'(s));
      wq = '{8'h5a};
      smb_write(addr_tab[(s + 1) % 3], 8'h03, 0);
      smb_write(addr_tab[s], 8'h03, 1);
      tick(6);
      check(cfg_image, exp_img);
      $display("strap %0d done", s);
    end
    wq = '{8'h05, 8'h00};
    smb_write(7'h6b, 8'h00, 2);
    tick(6);
    check(cfg_image, exp_img);
    watch(9'h005);
    oe_n_pin = 9'h001;
    tick(28);
    watch(9'h004);
    oe_n_pin = 9'h000;
    tick(28);
    watch(9'h005);
    $display("output gating done");
    wq = '{8'h11, 8'h22};
    smb_write(7'h6b, 8'h07, 2);
    tick(6);
    check(cfg_image, exp_img);
    // a stalled buffer holds two bytes, the third must be refused
    cfg_hold = 1'b1;
    wq = '{8'haa, 8'hbb, 8'hcc};
    smb_write(7'h6b, 8'h02, 2);
    check(cfg_image[23:16], 8'hff);
    cfg_hold = 1'b0;
    tick(6);
    check(cfg_image, exp_img);
    $display("buffer done");
    power_good_pin = 1'b0;
    tick(8);
    check(powered_down, 1'b1);
    watch(9'h000);
    wq = '{8'h00};
    smb_write(7'h6b, 8'h00, 0);
    power_good_pin = 1'b1;
    tick(WAKE + 30);
    check(powered_down, 1'b0);
    watch(9'h005);
    $display("power down done");
    ref_run = 1'b0;
    tick(80);
    check(smb_active, 1'b0);
    watch(9'h005);
    smb_write(7'h6b, 8'h00, 0);
    ref_run = 1'b1;
    tick(30);
    check(smb_active, 1'b1);
    check(cfg_image, exp_img);
    $display("reference stop done");
    final_report();
  end
endmodule
